// ---- split_timer_consts.svh ----
// register offsets, field positions and reset values of the split timer
`ifndef SPLIT_TIMER_CONSTS_SVH
`define SPLIT_TIMER_CONSTS_SVH
`define ADDR_RELOAD_LOW    8'hCA
`define ADDR_LOW_COUNTER   8'hCC
`define ADDR_RELOAD_HIGH   8'hCE
`define ADDR_HIGH_COUNTER  8'hCD
`define ADDR_CONTROL       8'hC8
`define ADDR_CLOCK_CTRL    8'hC9
`define ADDR_IRQ_STATUS    8'hCB
`define ADDR_IRQ_MASK      8'hCF
`define CTL_HIGH_FLAG      7
`define CTL_LOW_FLAG       6
`define CTL_LOW_IRQ_EN     5
`define CTL_CAPTURE_EN     4
`define CTL_SPLIT          3
`define CTL_RUN            2
`define CTL_EXT_CLK        0
`define CKC_HIGH_SEL       1
`define CKC_LOW_SEL        0
`define IRQ_HIGH           1
`define IRQ_LOW            0
`define BYTE_ZERO          8'h00
`define BYTE_MAX           8'hFF
`define SYS_DIV            12
`define EXT_DIV            8
`endif

// ---- split_timer_pkg.sv ----
// types of the split timer
package split_timer_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        SRC_SYS12 = 2'b00,
        SRC_EXT8  = 2'b01,
        SRC_SYS   = 2'b11
    } clk_src_t;
endpackage

// ---- tick_select.sv ----
// count-enable source for one 8-bit half
module tick_select (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic fast_sel,
    input  wire logic ext_sel,
    input  wire logic sys12_tick,
    input  wire logic ext8_tick,
    output logic      tick
);
    import split_timer_pkg::*;
    clk_src_t src;
    always_comb begin
        if (fast_sel) begin
            src = SRC_SYS;
        end else if (ext_sel) begin
            src = SRC_EXT8;
        end else begin
            src = SRC_SYS12;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            case (src)
                SRC_SYS:  tick <= 1'b1;
                SRC_EXT8: tick <= ext8_tick;
                default:  tick <= sys12_tick;
            endcase
        end
    end
endmodule // tick_select

// ---- split_timer.sv ----
// split-mode timer: two 8-bit auto-reload counters with registers and interrupt
`include "split_timer_consts.svh"
module split_timer #(
    parameter int SYS_DIV = `SYS_DIV,
    parameter int EXT_DIV = `EXT_DIV
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 ext_clk,
    input  wire logic [7:0]           addr,
    input  wire split_timer_pkg::byte_t wdata,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    output split_timer_pkg::byte_t    rdata,
    output logic                      irq
);
    import split_timer_pkg::*;

    byte_t      reload_low_ff;
    byte_t      reload_high_ff;
    byte_t      low_counter_ff;
    byte_t      high_counter_ff;
    byte_t      rdata_ff;
    logic       high_flag_ff;
    logic       low_flag_ff;
    logic       low_irq_en_ff;
    logic       capture_en_ff;
    logic       split_ff;
    logic       run_ff;
    logic       ext_sel_ff;
    logic       high_sel_ff;
    logic       low_sel_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_mask_ff;
    logic       irq_ff;
    logic [3:0] sys_div_ff;
    logic       sys12_tick_ff;
    logic       ext_meta_ff;
    logic       ext_sync_ff;
    logic       ext_prev_ff;
    logic [2:0] ext_div_ff;
    logic       ext8_tick_ff;
    logic       high_tick;
    logic       low_tick;
    logic       split_on;
    logic       high_ovf;
    logic       low_ovf;
    logic       wr_ctl;
    logic       wr_low_cnt;
    logic       wr_high_cnt;
    byte_t      control_value;
    byte_t      nxt_rdata;

    assign split_on = split_ff && !capture_en_ff;
    assign high_ovf = split_on && run_ff && high_tick && (high_counter_ff == `BYTE_MAX);
    assign low_ovf  = split_on && low_tick && (low_counter_ff == `BYTE_MAX);
    assign wr_ctl      = wr_en && (addr == `ADDR_CONTROL);
    assign wr_low_cnt  = wr_en && (addr == `ADDR_LOW_COUNTER);
    assign wr_high_cnt = wr_en && (addr == `ADDR_HIGH_COUNTER);

    // system clock divided down to a one-cycle enable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sys_div_ff    <= 4'h0;
            sys12_tick_ff <= 1'b0;
        end else if (sys_div_ff == 4'(SYS_DIV - 1)) begin
            sys_div_ff    <= 4'h0;
            sys12_tick_ff <= 1'b1;
        end else begin
            sys_div_ff    <= sys_div_ff + 4'h1;
            sys12_tick_ff <= 1'b0;
        end
    end

    // external clock: two-stage sync, rising edge, then divide
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ext_meta_ff  <= 1'b0;
            ext_sync_ff  <= 1'b0;
            ext_prev_ff  <= 1'b0;
            ext_div_ff   <= 3'h0;
            ext8_tick_ff <= 1'b0;
        end else begin
            ext_meta_ff  <= ext_clk;
            ext_sync_ff  <= ext_meta_ff;
            ext_prev_ff  <= ext_sync_ff;
            ext8_tick_ff <= 1'b0;
            if (ext_sync_ff && !ext_prev_ff) begin
                if (ext_div_ff == 3'(EXT_DIV - 1)) begin
                    ext_div_ff   <= 3'h0;
                    ext8_tick_ff <= 1'b1;
                end else begin
                    ext_div_ff <= ext_div_ff + 3'h1;
                end
            end
        end
    end

    tick_select u_high_sel (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .fast_sel   (high_sel_ff),
        .ext_sel    (ext_sel_ff),
        .sys12_tick (sys12_tick_ff),
        .ext8_tick  (ext8_tick_ff),
        .tick       (high_tick)
    );

    tick_select u_low_sel (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .fast_sel   (low_sel_ff),
        .ext_sel    (ext_sel_ff),
        .sys12_tick (sys12_tick_ff),
        .ext8_tick  (ext8_tick_ff),
        .tick       (low_tick)
    );

    // reload and configuration registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reload_low_ff  <= `BYTE_ZERO;
            reload_high_ff <= `BYTE_ZERO;
            low_irq_en_ff  <= 1'b0;
            capture_en_ff  <= 1'b0;
            split_ff       <= 1'b0;
            run_ff         <= 1'b0;
            ext_sel_ff     <= 1'b0;
            high_sel_ff    <= 1'b0;
            low_sel_ff     <= 1'b0;
            irq_mask_ff    <= 2'h0;
        end else if (wr_en) begin
            if (addr == `ADDR_RELOAD_LOW) begin
                reload_low_ff <= wdata;
            end else if (addr == `ADDR_RELOAD_HIGH) begin
                reload_high_ff <= wdata;
            end else if (addr == `ADDR_CONTROL) begin
                low_irq_en_ff <= wdata[`CTL_LOW_IRQ_EN];
                capture_en_ff <= wdata[`CTL_CAPTURE_EN];
                split_ff      <= wdata[`CTL_SPLIT];
                run_ff        <= wdata[`CTL_RUN];
                ext_sel_ff    <= wdata[`CTL_EXT_CLK];
            end else if (addr == `ADDR_CLOCK_CTRL) begin
                high_sel_ff <= wdata[`CKC_HIGH_SEL];
                low_sel_ff  <= wdata[`CKC_LOW_SEL];
            end else if (addr == `ADDR_IRQ_MASK) begin
                irq_mask_ff <= wdata[1:0];
            end
        end
    end

    // low counter: overflow reloads, else counts; software write loses to hardware reload
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_counter_ff <= `BYTE_ZERO;
        end else if (low_ovf) begin
            low_counter_ff <= reload_low_ff;
        end else if (wr_low_cnt) begin
            low_counter_ff <= wdata;
        end else if (split_on && low_tick) begin
            low_counter_ff <= low_counter_ff + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            high_counter_ff <= `BYTE_ZERO;
        end else if (high_ovf) begin
            high_counter_ff <= reload_high_ff;
        end else if (wr_high_cnt) begin
            high_counter_ff <= wdata;
        end else if (split_on && run_ff && high_tick) begin
            high_counter_ff <= high_counter_ff + 8'h01;
        end
    end

    // overflow flags: set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            high_flag_ff <= 1'b0;
            low_flag_ff  <= 1'b0;
        end else begin
            if (high_ovf) begin
                high_flag_ff <= 1'b1;
            end else if (wr_ctl) begin
                high_flag_ff <= wdata[`CTL_HIGH_FLAG];
            end
            if (low_ovf) begin
                low_flag_ff <= 1'b1;
            end else if (wr_ctl) begin
                low_flag_ff <= wdata[`CTL_LOW_FLAG];
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_status_ff <= 2'h0;
        end else begin
            if (high_ovf) begin
                irq_status_ff[`IRQ_HIGH] <= 1'b1;
            end else if (wr_en && addr == `ADDR_IRQ_STATUS && wdata[`IRQ_HIGH]) begin
                irq_status_ff[`IRQ_HIGH] <= 1'b0;
            end
            if (low_ovf && low_irq_en_ff) begin
                irq_status_ff[`IRQ_LOW] <= 1'b1;
            end else if (wr_en && addr == `ADDR_IRQ_STATUS && wdata[`IRQ_LOW]) begin
                irq_status_ff[`IRQ_LOW] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    always_comb begin
        control_value = `BYTE_ZERO;
        control_value[`CTL_HIGH_FLAG]  = high_flag_ff;
        control_value[`CTL_LOW_FLAG]   = low_flag_ff;
        control_value[`CTL_LOW_IRQ_EN] = low_irq_en_ff;
        control_value[`CTL_CAPTURE_EN] = capture_en_ff;
        control_value[`CTL_SPLIT]      = split_ff;
        control_value[`CTL_RUN]        = run_ff;
        control_value[`CTL_EXT_CLK]    = ext_sel_ff;
    end

    always_comb begin
        nxt_rdata = `BYTE_ZERO;
        if (addr == `ADDR_RELOAD_LOW) begin
            nxt_rdata = reload_low_ff;
        end else if (addr == `ADDR_RELOAD_HIGH) begin
            nxt_rdata = reload_high_ff;
        end else if (addr == `ADDR_LOW_COUNTER) begin
            nxt_rdata = low_counter_ff;
        end else if (addr == `ADDR_HIGH_COUNTER) begin
            nxt_rdata = high_counter_ff;
        end else if (addr == `ADDR_CONTROL) begin
            nxt_rdata = control_value;
        end else if (addr == `ADDR_CLOCK_CTRL) begin
            nxt_rdata = {6'h00, high_sel_ff, low_sel_ff};
        end else if (addr == `ADDR_IRQ_STATUS) begin
            nxt_rdata = {6'h00, irq_status_ff};
        end else if (addr == `ADDR_IRQ_MASK) begin
            nxt_rdata = {6'h00, irq_mask_ff};
        end
    end

    // read data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= `BYTE_ZERO;
        end else if (rd_en) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= `BYTE_ZERO;
        end
    end

    assign rdata = rdata_ff;
    assign irq   = irq_ff;
endmodule // split_timer

// ---- split_timer_asserts.sv ----
// port-level assertion checker for the split timer, bound to its top module
`include "split_timer_consts.svh"
module split_timer_asserts #(
    parameter int SYS_DIV = 12,
    parameter int EXT_DIV = 8
) (
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire logic                   ext_clk,
    input wire logic [7:0]             addr,
    input wire split_timer_pkg::byte_t wdata,
    input wire logic                   wr_en,
    input wire logic                   rd_en,
    input wire split_timer_pkg::byte_t rdata,
    input wire logic                   irq
);
    import split_timer_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // shadow of the mask; only two bits exist in the design
    byte_t mask_ff;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) mask_ff <= 8'h00;
        else if (wr_en && addr == `ADDR_IRQ_MASK) mask_ff <= wdata;
    end
    sequence s_wr(logic [7:0] a); wr_en && addr == a; endsequence
    sequence s_rd(logic [7:0] a); rd_en && addr == a; endsequence
    property p_rld_low; s_wr(`ADDR_RELOAD_LOW) ##1 s_rd(`ADDR_RELOAD_LOW) |=> rdata == $past(wdata, 2); endproperty
    property p_rld_high; s_wr(`ADDR_RELOAD_HIGH) ##1 s_rd(`ADDR_RELOAD_HIGH) |=> rdata == $past(wdata, 2); endproperty
    property p_low_wr;
        s_wr(`ADDR_LOW_COUNTER) ##1 s_rd(`ADDR_LOW_COUNTER) |=>
            rdata == $past(wdata, 2) || rdata == $past(wdata, 2) + 8'h01;
    endproperty
    property p_ctl_rd; s_wr(`ADDR_CONTROL) ##1 s_rd(`ADDR_CONTROL) |=> (rdata & 8'h3D) == ($past(wdata, 2) & 8'h3D); endproperty
    property p_rd_idle; !rd_en |=> rdata == 8'h00; endproperty
    property p_irq_mask; $rose(irq) |-> $past(mask_ff[1:0]) != 2'b00; endproperty
    property p_mask_off; s_wr(`ADDR_IRQ_MASK) and wdata[1:0] == 2'b00 |-> ##2 !irq; endproperty
    property p_irq_fall; $fell(irq) |-> $past(wr_en, 2); endproperty
    a_rld_low: assert property (p_rld_low) else $error("low reload readback wrong");
    a_rld_high: assert property (p_rld_high) else $error("high reload readback wrong");
    a_low_wr: assert property (p_low_wr) else $error("low counter write lost");
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_irq_mask: assert property (p_irq_mask) else $error("irq raised while masked");
    a_mask_off: assert property (p_mask_off) else $error("irq stays after mask off");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
endmodule // split_timer_asserts

bind split_timer split_timer_asserts #(.SYS_DIV(SYS_DIV), .EXT_DIV(EXT_DIV)) split_timer_asserts_inst (
    .ref_clk(ref_clk), .rst(rst), .ext_clk(ext_clk), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq));

// ---- test_split_timer.sv ----
// self-checking bench for the split timer
module test_split_timer;
    timeunit 1ns;
    timeprecision 100ps;
    import split_timer_pkg::*;
    logic        ref_clk = 1'b0, rst = 1'b1, ext_clk = 1'b0, wr_en = 1'b0, rd_en = 1'b0, irq;
    logic [7:0]  addr = 8'h00;
    byte_t       wdata = 8'h00, rdata, v;
    byte_t       ctl [2] = '{8'h1C, 8'h04};
    int          num_errors = 0, n_tests = 0, mdl [256];
    logic [31:0] seed = 32'ha273_6db0;
    split_timer #(.SYS_DIV(12), .EXT_DIV(8)) split_timer_inst (.ref_clk(ref_clk), .rst(rst),
        .ext_clk(ext_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    function automatic byte_t xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic conclude();
        $display("errors=%0d tests=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(byte_t got, int lo, int hi);
        n_tests++;
        if ($isunknown(got) || got < lo || got > hi) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo[7:0], hi[7:0]);
        end
    endtask
    // the write strobe stays up until the next task, so write then read can run back to back
    task automatic wr(logic [7:0] a, byte_t d);
        mdl[a] = d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
    endtask
    task automatic rd(logic [7:0] a, int lo, int hi, byte_t m = 8'hFF);
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        v = rdata & m;
        @(posedge ref_clk);
        chk(v, lo, hi);
    endtask
    task automatic idle(int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask
    initial begin
        repeat (6000) @(posedge ref_clk);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 8'hC0; a <= 8'hCF; a++) rd(a[7:0], 0, 0);
        wr(8'hCA, xs());
        rd(8'hCA, mdl[8'hCA], mdl[8'hCA]);
        wr(8'hCE, xs());
        rd(8'hCE, mdl[8'hCE], mdl[8'hCE]);
        wr(8'hC1, xs());
        rd(8'hC1, 0, 0);
        // low half on system clock, run bit left clear
        wr(8'hCF, 8'h03);
        wr(8'hC9, 8'h01);
        wr(8'hCA, 8'h80);
        wr(8'hCC, 8'hF0);
        rd(8'hCC, 8'hF0, 8'hF0);
        wr(8'hC8, 8'h08);
        idle(40);
        rd(8'hC8, 8'h48, 8'h48);
        rd(8'hCB, 0, 0);
        chk(byte_t'(irq), 0, 0);
        rd(8'hCD, 0, 0);
        rd(8'hCC, 8'h80, 8'hC0);
        wr(8'hC8, 8'h28);
        idle(150);
        rd(8'hCB, 1, 1, 8'h01);
        chk(byte_t'(irq), 1, 1);
        // slow the low half so no new overflow races the clear
        wr(8'hC9, 8'h00);
        wr(8'hCC, 8'h80);
        wr(8'hCB, 8'h01);
        idle(3);
        chk(byte_t'(irq), 0, 0);
        rd(8'hC8, 8'h40, 8'h40, 8'h40);
        wr(8'hC8, 8'h0C);
        wr(8'hCD, 8'h00);
        idle(120);
        rd(8'hCD, 9, 11);
        wr(8'hC9, 8'h02);
        wr(8'hCE, 8'h40);
        wr(8'hCD, 8'hF8);
        idle(20);
        rd(8'hC8, 8'h80, 8'h80, 8'h80);
        rd(8'hCB, 2, 2, 8'h02);
        rd(8'hCD, 8'h40, 8'h60);
        wr(8'hCF, 8'h02);
        idle(3);
        chk(byte_t'(irq), 1, 1);
        wr(8'hCF, 8'h00);
        idle(3);
        chk(byte_t'(irq), 0, 0);
        // external clock at a quarter of the system rate, still between bursts
        wr(8'hC9, 8'h00);
        wr(8'hC8, 8'h0D);
        wr(8'hCD, 8'h00);
        wr(8'hCC, 8'h00);
        repeat (80) begin
            ext_clk <= ~ext_clk;
            idle(2);
        end
        idle(8);
        rd(8'hCD, 4, 5);
        rd(8'hCC, 4, 5);
        foreach (ctl[i]) begin
            wr(8'hC9, 8'h03);
            wr(8'hC8, ctl[i]);
            rd(8'hC8, ctl[i], ctl[i], 8'h3D);
            wr(8'hCD, 8'h10);
            wr(8'hCC, 8'h20);
            idle(20);
            rd(8'hCD, 8'h10, 8'h10);
            rd(8'hCC, 8'h20, 8'h20);
        end
        conclude();
    end
endmodule // test_split_timer
